// ===== shared/dcc_pkg.sv
/*
 Constants, field layouts and carrier types for the dual comparator
 control block. Assumes an 8-bit register port addressed by byte.
*/
package dcc_pkg;

   //**************************************************************
   // Register map
   //**************************************************************
   localparam int         DCC_NUM_CMP    = 2;
   localparam logic [7:0] DCC_CTRL0_ADDR = 8'h9B;
   localparam logic [7:0] DCC_MODE0_ADDR = 8'h9D;
   localparam logic [7:0] DCC_CTRL1_ADDR = 8'h9A;
   localparam logic [7:0] DCC_MODE1_ADDR = 8'h9C;

   //**************************************************************
   // Reset values
   //**************************************************************
   localparam logic [7:0] DCC_CTRL_RESET = 8'h00;
   localparam logic [7:0] DCC_MODE_RESET = 8'h02;
   localparam logic [7:0] DCC_IDLE_DATA  = 8'h00;

   //**************************************************************
   // Field positions
   //**************************************************************
   localparam int DCC_ENABLE_POS   = 7;
   localparam int DCC_OUT_POS      = 6;
   localparam int DCC_RISE_POS     = 5;
   localparam int DCC_FALL_POS     = 4;
   localparam int DCC_POS_HYST_POS = 2;
   localparam int DCC_NEG_HYST_POS = 0;
   localparam int DCC_RIE_POS      = 5;
   localparam int DCC_FIE_POS      = 4;
   localparam int DCC_RESP_POS     = 0;

   //**************************************************************
   // Encodings
   //**************************************************************
   typedef enum logic [1:0] {
      DCC_RESP_FAST = 2'b00,
      DCC_RESP_MID1 = 2'b01,
      DCC_RESP_MID2 = 2'b10,
      DCC_RESP_SLOW = 2'b11
   } dcc_resp_t;

   typedef enum logic [1:0] {
      DCC_HYST_OFF  = 2'b00,
      DCC_HYST_5MV  = 2'b01,
      DCC_HYST_10MV = 2'b10,
      DCC_HYST_20MV = 2'b11
   } dcc_hyst_t;

   //**************************************************************
   // Carriers
   //**************************************************************
   typedef struct packed {
      logic      cmp_enable_bit;
      logic      cmp_output_state;
      logic      cmp_rise_flag;
      logic      cmp_fall_flag;
      dcc_hyst_t cmp_pos_hyst_sel;
      dcc_hyst_t cmp_neg_hyst_sel;
   } dcc_ctrl_t;

   typedef struct packed {
      logic [1:0] unused_hi;
      logic       cmp_rise_irq_en;
      logic       cmp_fall_irq_en;
      logic [1:0] unused_mid;
      dcc_resp_t  cmp_response_sel;
   } dcc_mode_t;

   typedef struct packed {
      logic      power_on;
      dcc_resp_t response;
      dcc_hyst_t pos_hyst;
      dcc_hyst_t neg_hyst;
   } dcc_analog_cfg_t;

endpackage

// ===== logic/dcc_sync.sv
/*
 Two-stage synchroniser for one comparator level.
 Assumes the input is asynchronous to clk; only stage two is read.
*/
`timescale 1ns/1ps
module dcc_sync
   import dcc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Level
   input  wire logic async_in,
   output logic      sync_out
);

   logic stage_one;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         stage_one <= 1'b0;
         sync_out  <= 1'b0;
      end
      else
      begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule // dcc_sync

// ===== logic/dcc_edge.sv
/*
 Edge detector and sticky rise/fall flags for one comparator.
 Assumes a synchronised level and one-cycle software write strobes.
*/
`timescale 1ns/1ps
module dcc_edge
   import dcc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Comparator
   input  wire logic enable,
   input  wire logic level,
   // Software write of the flags
   input  wire logic sw_write,
   input  wire logic sw_rise,
   input  wire logic sw_fall,
   // Flags
   output logic      rise_flag,
   output logic      fall_flag
);

   logic level_prev;
   logic rise_seen;
   logic fall_seen;
   logic next_rise_flag;
   logic next_fall_flag;

   // No edges reported while the comparator is off
   assign rise_seen = enable &  level & ~level_prev;
   assign fall_seen = enable & ~level &  level_prev;

   // Hardware set wins over a software write in the same cycle
   assign next_rise_flag = rise_seen | (sw_write ? sw_rise : rise_flag);
   assign next_fall_flag = fall_seen | (sw_write ? sw_fall : fall_flag);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         level_prev <= 1'b0;
         rise_flag  <= 1'b0;
         fall_flag  <= 1'b0;
      end
      else
      begin
         level_prev <= level;
         rise_flag  <= next_rise_flag;
         fall_flag  <= next_fall_flag;
      end
   end

endmodule // dcc_edge

// ===== logic/dcc_top.sv
/*
 Control and status logic for two analog comparators: register port,
 analog configuration, latched and raw outputs, edge flags and requests.
 Assumes the analog core delivers each comparator result as a level
 that is asynchronous to CLOCK, and a register master on CLOCK.
*/
// Our own choices: the strobed register port and the placing of the registers.
// What this block does
// - Two identical comparators; only first feeds reset
// - Latched and raw output per comparator
// - Raw output works without system clock
// - Output polled, interrupt source, pin-routable together
// - Disabled: outputs low, analog power off
// - Mode field selects response time and power
// - Mode 00 fastest, 11 slowest lowest power
// - Low four control bits set hysteresis
// - Positive hysteresis field independent of negative
// - Hysteresis 00 off,01 5,10 10,11 20 mV
// - Interrupts on rising and falling transitions
// - Falling transition sets falling-edge flag
// - Rising transition sets rising-edge flag
// - Flags stay set until software clears
// - Rising request passes only when enabled
// - Falling request passes only when enabled
// - Output state bit reads level, no side effect
// - State bit one when positive input higher
// - Enable bit one on, zero off
`timescale 1ns/1ps
module dcc_top
   import dcc_pkg::*;
(
   // Clock and reset
   input  wire logic             CLOCK,
   input  wire logic             RESET_N,
   // Register port
   input  wire logic [7:0]       REG_ADDR,
   input  wire logic [7:0]       REG_WDATA,
   input  wire logic             REG_WR,
   input  wire logic             REG_RD,
   output logic      [7:0]       REG_RDATA,
   // Analog core results
   input  wire logic             CMP0_ANALOG_IN,
   input  wire logic             CMP1_ANALOG_IN,
   // Analog core configuration
   output dcc_analog_cfg_t       CMP0_CFG,
   output dcc_analog_cfg_t       CMP1_CFG,
   // Crossbar outputs
   output logic                  CMP0_LATCHED_OUT,
   output logic                  CMP1_LATCHED_OUT,
   output logic                  CMP0_RAW_OUT,
   output logic                  CMP1_RAW_OUT,
   // Interrupt requests
   output logic                  CMP0_RISE_IRQ,
   output logic                  CMP0_FALL_IRQ,
   output logic                  CMP1_RISE_IRQ,
   output logic                  CMP1_FALL_IRQ,
   // Reset source toward the reset controller
   output logic                  CMP0_RESET_REQ
);

   //**************************************************************
   // Register storage
   //**************************************************************
   dcc_ctrl_t       cmp_control_reg [DCC_NUM_CMP];
   dcc_mode_t       cmp_mode_reg    [DCC_NUM_CMP];
   dcc_analog_cfg_t cfg_q           [DCC_NUM_CMP];
   logic            analog_in       [DCC_NUM_CMP];
   logic            level_sync      [DCC_NUM_CMP];
   logic            level_gated     [DCC_NUM_CMP];
   logic            latched_q       [DCC_NUM_CMP];
   logic            rise_flag       [DCC_NUM_CMP];
   logic            fall_flag       [DCC_NUM_CMP];
   logic            rise_irq_q      [DCC_NUM_CMP];
   logic            fall_irq_q      [DCC_NUM_CMP];
   logic            wr_ctrl         [DCC_NUM_CMP];
   logic            wr_mode         [DCC_NUM_CMP];
   logic            reset_req_q;

   //**************************************************************
   // Address decode
   //**************************************************************
   wire logic hit_ctrl0;
   wire logic hit_ctrl1;
   wire logic hit_mode0;
   wire logic hit_mode1;
   wire logic hit_any;

   assign hit_ctrl0 = (REG_ADDR == DCC_CTRL0_ADDR);
   assign hit_ctrl1 = (REG_ADDR == DCC_CTRL1_ADDR);
   assign hit_mode0 = (REG_ADDR == DCC_MODE0_ADDR);
   assign hit_mode1 = (REG_ADDR == DCC_MODE1_ADDR);
   assign hit_any   = hit_ctrl0 | hit_ctrl1 | hit_mode0 | hit_mode1;

   assign wr_ctrl[0] = REG_WR & hit_ctrl0;
   assign wr_ctrl[1] = REG_WR & hit_ctrl1;
   assign wr_mode[0] = REG_WR & hit_mode0;
   assign wr_mode[1] = REG_WR & hit_mode1;

   assign analog_in[0] = CMP0_ANALOG_IN;
   assign analog_in[1] = CMP1_ANALOG_IN;

   //**************************************************************
   // Per-comparator logic, identical for both
   //**************************************************************
   for (genvar i = 0; i < DCC_NUM_CMP; i++)
   begin : g_cmp
      dcc_ctrl_t       wr_ctrl_val;
      dcc_mode_t       wr_mode_val;
      dcc_ctrl_t       next_ctrl;
      dcc_mode_t       next_mode;
      dcc_analog_cfg_t next_cfg;
      logic            enabled;

      assign wr_ctrl_val = dcc_ctrl_t'(REG_WDATA);
      assign wr_mode_val = dcc_mode_t'(REG_WDATA);
      assign enabled     = cmp_control_reg[i].cmp_enable_bit;

      // Result synchronised here for every use except the raw outputs
      dcc_sync u_sync
      (
         .clk      (CLOCK),
         .rst_n    (RESET_N),
         .async_in (analog_in[i]),
         .sync_out (level_sync[i])
      );

      // Analog core is off while disabled, so its level means nothing
      assign level_gated[i] = level_sync[i] & enabled;

      dcc_edge u_edge
      (
         .clk       (CLOCK),
         .rst_n     (RESET_N),
         .enable    (enabled),
         .level     (level_sync[i]),
         .sw_write  (wr_ctrl[i]),
         .sw_rise   (wr_ctrl_val.cmp_rise_flag),
         .sw_fall   (wr_ctrl_val.cmp_fall_flag),
         .rise_flag (rise_flag[i]),
         .fall_flag (fall_flag[i])
      );

      // Control register: state bit is read-only, flags live in u_edge
      always_comb
      begin
         next_ctrl = cmp_control_reg[i];
         if (wr_ctrl[i])
         begin
            next_ctrl.cmp_enable_bit   = wr_ctrl_val.cmp_enable_bit;
            next_ctrl.cmp_pos_hyst_sel = wr_ctrl_val.cmp_pos_hyst_sel;
            next_ctrl.cmp_neg_hyst_sel = wr_ctrl_val.cmp_neg_hyst_sel;
         end
         next_ctrl.cmp_output_state = 1'b0;
         next_ctrl.cmp_rise_flag    = 1'b0;
         next_ctrl.cmp_fall_flag    = 1'b0;
      end

      // Mode register: unused bits never store
      always_comb
      begin
         next_mode = cmp_mode_reg[i];
         if (wr_mode[i])
         begin
            next_mode.cmp_rise_irq_en  = wr_mode_val.cmp_rise_irq_en;
            next_mode.cmp_fall_irq_en  = wr_mode_val.cmp_fall_irq_en;
            next_mode.cmp_response_sel = wr_mode_val.cmp_response_sel;
         end
         next_mode.unused_hi  = 2'h0;
         next_mode.unused_mid = 2'h0;
      end

      // Configuration for the analog core, encodings passed unchanged
      assign next_cfg.power_on = next_ctrl.cmp_enable_bit;
      assign next_cfg.response = next_mode.cmp_response_sel;
      assign next_cfg.pos_hyst = next_ctrl.cmp_pos_hyst_sel;
      assign next_cfg.neg_hyst = next_ctrl.cmp_neg_hyst_sel;

      // Control register
      always_ff @(posedge CLOCK)
      begin
         if (!RESET_N)
         begin
            cmp_control_reg[i] <= dcc_ctrl_t'(DCC_CTRL_RESET);
         end
         else
         begin
            cmp_control_reg[i] <= next_ctrl;
         end
      end

      // Mode register
      always_ff @(posedge CLOCK)
      begin
         if (!RESET_N)
         begin
            cmp_mode_reg[i] <= dcc_mode_t'(DCC_MODE_RESET);
         end
         else
         begin
            cmp_mode_reg[i] <= next_mode;
         end
      end

      // Taken from the next register value, so the analog core
      // and the register never disagree for a cycle
      always_ff @(posedge CLOCK)
      begin
         if (!RESET_N)
         begin
            cfg_q[i] <= dcc_analog_cfg_t'({1'b0, DCC_MODE_RESET[1:0], DCC_CTRL_RESET[3:0]});
         end
         else
         begin
            cfg_q[i] <= next_cfg;
         end
      end

      // Latched crossbar output
      always_ff @(posedge CLOCK)
      begin
         if (!RESET_N)
         begin
            latched_q[i] <= 1'b0;
         end
         else
         begin
            latched_q[i] <= level_gated[i];
         end
      end
   end

   //**************************************************************
   // Interrupt requests
   //**************************************************************
   for (genvar k = 0; k < DCC_NUM_CMP; k++)
   begin : g_irq
      // Registered, so a mask write never glitches the request line
      always_ff @(posedge CLOCK)
      begin
         if (!RESET_N)
         begin
            rise_irq_q[k] <= 1'b0;
            fall_irq_q[k] <= 1'b0;
         end
         else
         begin
            rise_irq_q[k] <= rise_flag[k] & cmp_mode_reg[k].cmp_rise_irq_en;
            fall_irq_q[k] <= fall_flag[k] & cmp_mode_reg[k].cmp_fall_irq_en;
         end
      end
   end

   //**************************************************************
   // Reset source, first comparator only
   //**************************************************************
   // Asks for reset while comparator 0 is on and its positive input is low
   always_ff @(posedge CLOCK)
   begin
      if (!RESET_N)
      begin
         reset_req_q <= 1'b0;
      end
      else
      begin
         reset_req_q <= cmp_control_reg[0].cmp_enable_bit & ~level_sync[0];
      end
   end

   //**************************************************************
   // Read path
   //**************************************************************
   wire logic [7:0] ctrl_view [DCC_NUM_CMP];
   wire logic [7:0] mode_view [DCC_NUM_CMP];
   logic      [7:0] read_mux;

   for (genvar j = 0; j < DCC_NUM_CMP; j++)
   begin : g_view
      // Reading has no effect on any state
      assign ctrl_view[j] = {cmp_control_reg[j].cmp_enable_bit,
                             level_gated[j],
                             rise_flag[j],
                             fall_flag[j],
                             cmp_control_reg[j].cmp_pos_hyst_sel,
                             cmp_control_reg[j].cmp_neg_hyst_sel};
      assign mode_view[j] = cmp_mode_reg[j];
   end

   always_comb
   begin
      if (hit_ctrl0)
      begin
         read_mux = ctrl_view[0];
      end
      else if (hit_ctrl1)
      begin
         read_mux = ctrl_view[1];
      end
      else if (hit_mode0)
      begin
         read_mux = mode_view[0];
      end
      else if (hit_mode1)
      begin
         read_mux = mode_view[1];
      end
      else
      begin
         read_mux = DCC_IDLE_DATA;
      end
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge CLOCK)
   begin
      if (!RESET_N)
      begin
         REG_RDATA <= DCC_IDLE_DATA;
      end
      else
      begin
         REG_RDATA <= (REG_RD & hit_any) ? read_mux : DCC_IDLE_DATA;
      end
   end

   //**************************************************************
   // Outputs
   //**************************************************************
   assign CMP0_CFG         = cfg_q[0];
   assign CMP1_CFG         = cfg_q[1];
   assign CMP0_LATCHED_OUT = latched_q[0];
   assign CMP1_LATCHED_OUT = latched_q[1];
   assign CMP0_RISE_IRQ    = rise_irq_q[0];
   assign CMP0_FALL_IRQ    = fall_irq_q[0];
   assign CMP1_RISE_IRQ    = rise_irq_q[1];
   assign CMP1_FALL_IRQ    = fall_irq_q[1];
   assign CMP0_RESET_REQ   = reset_req_q;

   //**************************************************************
   // Raw outputs
   //**************************************************************
   // Raw path bypasses every flop so it keeps working with CLOCK stopped;
   // the held enable flop forces it low while the comparator is off
   assign CMP0_RAW_OUT = CMP0_ANALOG_IN & cfg_q[0].power_on;
   assign CMP1_RAW_OUT = CMP1_ANALOG_IN & cfg_q[1].power_on;

endmodule // dcc_top

// ===== dv/dcc_props.sv
/*
 Port-level checker for the dual comparator control block.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module dcc_props
   import dcc_pkg::*;
(
   // Clock and reset
   input wire logic            CLOCK,
   input wire logic            RESET_N,
   // Register port
   input wire logic [7:0]      REG_ADDR,
   input wire logic [7:0]      REG_WDATA,
   input wire logic            REG_WR,
   input wire logic            REG_RD,
   input wire logic [7:0]      REG_RDATA,
   // Comparator side
   input wire logic            CMP0_ANALOG_IN,
   input wire logic            CMP1_ANALOG_IN,
   input wire dcc_analog_cfg_t CMP0_CFG,
   input wire dcc_analog_cfg_t CMP1_CFG,
   input wire logic            CMP0_LATCHED_OUT,
   input wire logic            CMP0_RAW_OUT,
   input wire logic            CMP1_RAW_OUT,
   input wire logic            CMP0_RESET_REQ
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);

   //**************************************************************
   // Properties
   //**************************************************************
   AST_RAW_GATED: assert property (CMP0_RAW_OUT == (CMP0_ANALOG_IN && CMP0_CFG.power_on) &&
      CMP1_RAW_OUT == (CMP1_ANALOG_IN && CMP1_CFG.power_on)) else $error("raw output not gated input");
   AST_LATCH_OFF: assert property (!CMP0_CFG.power_on [*2] |-> !CMP0_LATCHED_OUT)
      else $error("latched output high while disabled");
   // Two sync stages plus the output flop
   AST_LATCH_TRACK: assert property (CMP0_CFG.power_on [*4] |-> CMP0_LATCHED_OUT == $past(CMP0_ANALOG_IN, 3))
      else $error("latched output does not follow input");
   AST_RESET_REQ: assert property (CMP0_CFG.power_on [*2] |-> CMP0_RESET_REQ != CMP0_LATCHED_OUT)
      else $error("reset request not inverse of level");
   AST_RD_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == DCC_IDLE_DATA)
      else $error("read data outside read slot");
   AST_RD_STATE: assert property ($past(REG_RD) && $past(REG_ADDR) == DCC_CTRL0_ADDR
      |-> REG_RDATA[DCC_OUT_POS] == CMP0_LATCHED_OUT) else $error("state bit differs from level");
   AST_MODE_RD: assert property ($past(REG_RD) && $past(REG_ADDR) == DCC_MODE0_ADDR
      |-> REG_RDATA[7:6] == 2'h0 && REG_RDATA[3:2] == 2'h0) else $error("unused mode bits not zero");
   AST_CFG_RST: assert property ($rose(RESET_N) |-> CMP0_CFG == {1'b0, DCC_MODE_RESET[1:0], DCC_CTRL_RESET[3:0]})
      else $error("configuration reset value wrong");
   AST_CTRL_WR: assert property (REG_WR && REG_ADDR == DCC_CTRL1_ADDR |=>
      {CMP1_CFG.power_on, 3'h0, CMP1_CFG.pos_hyst, CMP1_CFG.neg_hyst} == ($past(REG_WDATA) & 8'h8F))
      else $error("control write not applied");
   AST_MODE_WR: assert property (REG_WR && REG_ADDR == DCC_MODE1_ADDR |=>
      {6'h00, CMP1_CFG.response} == ($past(REG_WDATA) & 8'h03)) else $error("response write not applied");

   COV_RISE: cover property ($rose(CMP0_LATCHED_OUT));
   COV_REQ: cover property ($rose(CMP0_RESET_REQ));
   COV_STATE: cover property ($past(REG_RD) && REG_RDATA[DCC_OUT_POS]);
endmodule // dcc_props

bind dcc_top dcc_props dcc_props_i (.CLOCK(CLOCK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CMP0_ANALOG_IN(CMP0_ANALOG_IN),
   .CMP1_ANALOG_IN(CMP1_ANALOG_IN), .CMP0_CFG(CMP0_CFG), .CMP1_CFG(CMP1_CFG), .CMP0_LATCHED_OUT(CMP0_LATCHED_OUT),
   .CMP0_RAW_OUT(CMP0_RAW_OUT), .CMP1_RAW_OUT(CMP1_RAW_OUT), .CMP0_RESET_REQ(CMP0_RESET_REQ));

// ===== dv/dcc_core_model.sv
/*
 Behavioural analog comparator core with hysteresis and response delay.
 Assumes the configuration struct from the block and a millivolt input.
*/
`timescale 1ns/1ps
module dcc_core_model
   import dcc_pkg::*;
(
   // Configuration
   input  wire dcc_analog_cfg_t   cfg,
   // Positive minus negative input, mV
   input  wire logic signed [15:0] diff_mv,
   // Result
   output logic                   result
);
   logic lvl = 1'b0;

   function automatic int hyst_mv(input dcc_hyst_t h);
      return (h == DCC_HYST_OFF) ? 0 : (5 << (int'(h) - 1));
   endfunction

   // Separate thresholds per direction
   always @(diff_mv or cfg)
   begin
      if (diff_mv > hyst_mv(cfg.pos_hyst))
         lvl = 1'b1;
      else if (diff_mv < -hyst_mv(cfg.neg_hyst))
         lvl = 1'b0;
   end

   // Unpowered core gives no valid level, so spurious edges appear at power-on
   always @(lvl or cfg.power_on or cfg.response)
      result <= #((int'(cfg.response) + 1) * 8 + 3) (cfg.power_on ? lvl : ~lvl);
endmodule // dcc_core_model

// ===== dv/tb_top.sv
/*
 Self-checking bench for the dual comparator control block.
 Assumes a 25 MHz clock and register reads returning one cycle later.
*/
`timescale 1ns/1ps
module tb_top
   import dcc_pkg::*;
;
   localparam logic [7:0] CTL_A [2]  = '{DCC_CTRL0_ADDR, DCC_CTRL1_ADDR};
   localparam logic [7:0] MODE_A [2] = '{DCC_MODE0_ADDR, DCC_MODE1_ADDR};

   logic                clock     = 1'b0;
   logic                clk_run   = 1'b1;
   logic                reset_n   = 1'b0;
   logic                reg_wr    = 1'b0;
   logic                reg_rd    = 1'b0;
   logic [7:0]          reg_addr  = 8'h00;
   logic [7:0]          reg_wdata = 8'h00;
   logic [7:0]          reg_rdata;
   logic                lat [2];
   logic                raw [2];
   logic                rirq [2];
   logic                firq [2];
   logic                ana [2];
   logic                reset_req;
   dcc_analog_cfg_t     cfg [2];
   logic signed [15:0]  dmv [2]   = '{16'sh0000, 16'sh0000};
   int                  failures  = 0;
   int                  cmp_count = 0;

   dcc_top dcc_top_i (.CLOCK(clock), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CMP0_ANALOG_IN(ana[0]), .CMP1_ANALOG_IN(ana[1]),
      .CMP0_CFG(cfg[0]), .CMP1_CFG(cfg[1]), .CMP0_LATCHED_OUT(lat[0]), .CMP1_LATCHED_OUT(lat[1]),
      .CMP0_RAW_OUT(raw[0]), .CMP1_RAW_OUT(raw[1]), .CMP0_RISE_IRQ(rirq[0]), .CMP0_FALL_IRQ(firq[0]),
      .CMP1_RISE_IRQ(rirq[1]), .CMP1_FALL_IRQ(firq[1]), .CMP0_RESET_REQ(reset_req));

   for (genvar g = 0; g < 2; g++)
   begin : g_core
      dcc_core_model dcc_core_model_i (.cfg(cfg[g]), .diff_mv(dmv[g]), .result(ana[g]));
   end

   // Gate lets the raw path be seen with no system clock
   initial
      forever #20 clock = clk_run ? ~clock : clock;

   //**************************************************************
   // Access tasks
   //**************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, what);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   //**************************************************************
   // Per-comparator sequence
   //**************************************************************
   task automatic cmp_test(input int n);
      logic [7:0] c;
      logic [7:0] m;
      c = CTL_A[n];
      m = MODE_A[n];
      wr(c, 8'h80);
      chk(cfg[n].power_on, 8'h01, "power on");
      dmv[n] <= 16'sh001E;
      settle(6);
      wr(c, 8'h80);
      for (int h = 0; h < 4; h++)
      begin
         wr(c, 8'h80 | 8'(h << 2) | 8'(3 - h));
         chk({cfg[n].pos_hyst, cfg[n].neg_hyst}, 8'((h << 2) | (3 - h)), "hysteresis");
      end
      for (int r = 0; r < 4; r++)
      begin
         wr(m, 8'(r));
         chk(cfg[n].response, 8'(r), "response");
      end
      wr(m, 8'hFF);
      rd(m, 8'h33, "mode readback");
      wr(c, 8'hC0);
      rd(c, 8'hC0, "state high");
      rd(c, 8'hC0, "state reread");
      chk({lat[n], raw[n]}, 8'h03, "outputs high");
      dmv[n] <= 16'shFFE2;
      settle(6);
      rd(c, 8'h90, "fall flag");
      chk({rirq[n], firq[n], reset_req}, 8'(2 + (n == 0)), "after fall");
      dmv[n] <= 16'sh001E;
      settle(6);
      rd(c, 8'hF0, "both flags");
      chk({rirq[n], firq[n]}, 8'h03, "both requests");
      clk_run = 1'b0;
      dmv[n] = 16'shFFE2;
      #200;
      chk(raw[n], 8'h00, "raw low, clock stopped");
      dmv[n] = 16'sh001E;
      #200;
      chk(raw[n], 8'h01, "raw high, clock stopped");
      clk_run = 1'b1;
      wr(m, 8'h23);
      settle(2);
      chk({rirq[n], firq[n]}, 8'h02, "rise enable only");
      wr(m, 8'h13);
      settle(2);
      chk({rirq[n], firq[n]}, 8'h01, "fall enable only");
      wr(c, 8'h80);
      rd(c, 8'hC0, "flags cleared");
      wr(c, 8'hA0);
      rd(c, 8'hE0, "rise flag set by write");
      wr(c, 8'h00);
      chk(cfg[n].power_on, 8'h00, "power off");
      dmv[n] <= 16'shFFE2;
      settle(6);
      dmv[n] <= 16'sh001E;
      settle(6);
      rd(c, 8'h00, "disabled, no edges");
      chk({lat[n], raw[n], reset_req}, 8'h00, "disabled outputs");
   endtask

   //**************************************************************
   // Main sequence
   //**************************************************************
   initial
   begin
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         rd(CTL_A[i], DCC_CTRL_RESET, "control reset");
         rd(MODE_A[i], DCC_MODE_RESET, "mode reset");
      end
      rd(8'h9E, 8'h00, "unmapped read");
      wr(8'h9E, 8'hFF);
      rd(CTL_A[0], 8'h00, "unmapped write ignored");
      $display("Reset and map test done");
      for (int n = 0; n < 2; n++)
      begin
         cmp_test(n);
         $display("Comparator %0d test done", n);
      end
      results();
   end

   initial
   begin
      #200000;
      failures++;
      $display("wrong value at %0t ns: run timed out", $time);
      results();
   end
endmodule // tb_top
